// *** rtl/tbcp_timer.sv ***
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Buffers only on channels 0, 3, 4
// - Compare match loads buffer into register
// - Capture shifts old register into buffer
// - Channels 1 and 2 form 32-bit counter
// - Upper counts lower overflow up, underflow down
// - Lower underflows only in phase mode
// - Phase mode channel 1 ignores cascade
// - Match drives pin 0, 1 or toggle
// - PWM1 pairs A/B, C/D on pins A, C
// - PWM1 initial level from A or C
// - PWM1 equal pair leaves pin unchanged
// - PWM1 gives up to eight phases
// - PWM2 clear returns pins to initial
// - PWM2 equal cycle and duty: no change
// - PWM2 seven phases with synchronous channels
// - PWM2 period register pin not driven
// - Phase mode on channels 1, 2 only
// - Phase mode ignores prescaler, keeps rest
// - Phase overflow and underflow set flags
// - Status bit shows count direction
// - Times-four decode, A leading counts up
module tbcp_timer import tbcp_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [8:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Encoder phases
  input  wire logic              ext_phase_a_ch1,
  input  wire logic              ext_phase_b_ch1,
  input  wire logic              ext_phase_a_ch2,
  input  wire logic              ext_phase_b_ch2,
  // Timer pins, index [channel][A,B,C,D]
  input  wire logic [4:0][3:0]   timer_pin_in,
  output logic      [4:0][3:0]   timer_pin_out,
  output logic      [4:0][3:0]   timer_pin_oe
);
  typedef struct packed {
    logic [4:0][15:0]       cnt;
    logic [4:0][3:0][15:0]  gr;
    logic [4:0][15:0]       ctrl;
    logic [4:0][15:0]       ioc;
    logic [4:0][5:0]        flags;
    logic [4:0]             dir;
    logic [4:0][3:0]        pin;
    logic [4:0][3:0]        oe;
    logic [4:0][1:0]        cap_prev;
    logic [4:0]             start;
    logic [5:0]             pre;
    logic                   waitreq;
    logic [31:0]            rdata;
  } tbcp_top_st_t;

  tbcp_top_st_t     st_reg;
  tbcp_top_st_t     st_next;
  logic [4:0]       up;
  logic [4:0]       dn;
  logic [4:0]       ovf;
  logic [4:0]       unf;
  logic [4:0]       own_clr;
  logic [4:0]       clr;
  logic [4:0][3:0]  match;
  logic [4:0][3:0]  capt;
  logic [4:0][5:0]  fclr;
  logic [4:0]       ph_up;
  logic [4:0]       ph_dn;
  logic [4:0][1:0]  cap_lvl;
  logic [4:0][1:0]  cap_rise;
  logic             req_new;
  logic             wr_en;
  logic             chan_ok;
  logic [2:0]       regi;
  int               chn;
  tbcp_mode_t       md;
  tbcp_clr_t        src;
  logic             phase_c;
  logic             tick;
  logic             sync_clr;
  logic             has_cd;
  logic             per_ok;
  int               per;

  tbcp_phase_if ph1_if ();
  tbcp_phase_if ph2_if ();

  tbcp_quad_dec u_quad1 (
    .clk     (clk),
    .reset_n (reset_n),
    .phase_a (ext_phase_a_ch1),
    .phase_b (ext_phase_b_ch1),
    .steps   (ph1_if.dec)
  );

  tbcp_quad_dec u_quad2 (
    .clk     (clk),
    .reset_n (reset_n),
    .phase_a (ext_phase_a_ch2),
    .phase_b (ext_phase_b_ch2),
    .steps   (ph2_if.dec)
  );

  // Capture inputs are pins A and B of each channel
  tbcp_sync #(.WIDTH(10)) u_cap_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({timer_pin_in[4][1:0], timer_pin_in[3][1:0], timer_pin_in[2][1:0],
                timer_pin_in[1][1:0], timer_pin_in[0][1:0]}),
    .q       (cap_lvl)
  );

  assign ph_up    = {2'b00, ph2_if.up, ph1_if.up, 1'b0};
  assign ph_dn    = {2'b00, ph2_if.dn, ph1_if.dn, 1'b0};
  assign cap_rise = cap_lvl & ~st_reg.cap_prev;

  function automatic logic apply_act(input logic [1:0] act, input logic lvl);
    case (tbcp_act_t'(act))
      ACT_LOW:    apply_act = 1'b0;
      ACT_HIGH:   apply_act = 1'b1;
      ACT_TOGGLE: apply_act = !lvl;
      default:    apply_act = lvl;
    endcase
  endfunction : apply_act

  always_comb begin
    md       = MODE_NORMAL;
    src      = CLR_NONE;
    phase_c  = 1'b0;
    tick     = 1'b0;
    sync_clr = 1'b0;
    has_cd   = 1'b0;
    per_ok   = 1'b0;
    per      = 0;
    st_next  = st_reg;
    up       = '0;
    dn       = '0;
    ovf      = '0;
    unf      = '0;
    own_clr  = '0;
    clr      = '0;
    match    = '0;
    capt     = '0;
    fclr     = '0;
    regi     = avs_address[4:2];
    chn      = int'(avs_address[7:5]);
    chan_ok  = !avs_address[8] && (chn < NCH);
    req_new  = (avs_read || avs_write) && st_reg.waitreq;
    wr_en    = avs_write && !st_reg.waitreq;
    st_next.pre      = st_reg.pre + 6'h01;
    st_next.cap_prev = cap_lvl;
    // One wait cycle, then a single acknowledge cycle
    st_next.waitreq  = !req_new;
    if (req_new) begin
      st_next.rdata = '0;
      if (avs_address == OFS_START) begin
        st_next.rdata[4:0] = st_reg.start;
      end else if (chan_ok) begin
        case (regi)
          REG_CTRL:   st_next.rdata[15:0] = st_reg.ctrl[chn];
          REG_IOC:    st_next.rdata[15:0] = st_reg.ioc[chn];
          REG_STATUS: st_next.rdata[6:0]  = {st_reg.dir[chn], st_reg.flags[chn]};
          REG_CNT:    st_next.rdata[15:0] = st_reg.cnt[chn];
          default: begin
            if (!regi[1] || BUF_CH_MASK[chn]) begin
              st_next.rdata[15:0] = st_reg.gr[chn][regi[1:0]];
            end
          end
        endcase
      end
    end
    if (wr_en && chan_ok && regi == REG_STATUS) begin
      fclr[chn] = avs_writedata[5:0];
    end
    // Lower half first so the upper half sees its carry in the same cycle
    for (int c = NCH - 1; c >= 0; c--) begin
      md      = tbcp_mode_t'(st_reg.ctrl[c][CTL_MODE_LSB +: 2]);
      src     = tbcp_clr_t'(st_reg.ctrl[c][CTL_CLR_LSB +: 2]);
      phase_c = (md == MODE_PHASE) && PHASE_CH_MASK[c];
      has_cd  = BUF_CH_MASK[c];
      case (st_reg.ctrl[c][CTL_PSC_LSB +: 2])
        2'h0:    tick = 1'b1;
        2'h1:    tick = (st_reg.pre & PRE_DIV4) == PRE_DIV4;
        2'h2:    tick = (st_reg.pre & PRE_DIV16) == PRE_DIV16;
        default: tick = st_reg.pre == PRE_DIV64;
      endcase
      if (st_reg.start[c]) begin
        if (phase_c) begin
          up[c] = ph_up[c];
          dn[c] = ph_dn[c];
        end else if (c == CASC_UPPER && st_reg.ctrl[c][CTL_CASC]) begin
          up[c] = ovf[CASC_LOWER];
          dn[c] = unf[CASC_LOWER];
        end else begin
          up[c] = tick;
        end
      end
      ovf[c] = up[c] && st_reg.cnt[c] == CNT_MAX;
      unf[c] = dn[c] && phase_c && st_reg.cnt[c] == CNT_ZERO;
      for (int x = 0; x < 4; x++) begin
        if (x < 2 && st_reg.ioc[c][IOC_CAP_LSB + x]) begin
          capt[c][x] = cap_rise[c][x];
        end else if ((x < 2 || (has_cd && !st_reg.ctrl[c][CTL_BUF_LSB + (x & 1)]))
                     && (up[c] || dn[c])) begin
          match[c][x] = st_reg.cnt[c] == st_reg.gr[c][x];
        end
      end
      case (src)
        CLR_A:   own_clr[c] = match[c][0] || capt[c][0];
        CLR_B:   own_clr[c] = match[c][1] || capt[c][1];
        default: own_clr[c] = 1'b0;
      endcase
    end
    for (int c = 0; c < NCH; c++) begin
      sync_clr = sync_clr || (own_clr[c] && st_reg.ctrl[c][CTL_SYNC]);
    end
    for (int c = 0; c < NCH; c++) begin
      clr[c] = own_clr[c] || (st_reg.ctrl[c][CTL_SYNC] && sync_clr
               && tbcp_clr_t'(st_reg.ctrl[c][CTL_CLR_LSB +: 2]) == CLR_SYNC);
    end
    for (int c = 0; c < NCH; c++) begin
      md      = tbcp_mode_t'(st_reg.ctrl[c][CTL_MODE_LSB +: 2]);
      src     = tbcp_clr_t'(st_reg.ctrl[c][CTL_CLR_LSB +: 2]);
      has_cd  = BUF_CH_MASK[c];
      per_ok  = (src == CLR_A) || (src == CLR_B);
      per     = (src == CLR_B) ? 1 : 0;
      if (clr[c]) begin
        st_next.cnt[c] = CNT_ZERO;
      end else if (up[c]) begin
        st_next.cnt[c] = st_reg.cnt[c] + 16'h0001;
      end else if (dn[c]) begin
        st_next.cnt[c] = st_reg.cnt[c] - 16'h0001;
      end
      if (up[c]) begin
        st_next.dir[c] = 1'b1;
      end else if (dn[c]) begin
        st_next.dir[c] = 1'b0;
      end
      // A new event beats a clear written in the same cycle
      st_next.flags[c] = (st_reg.flags[c] & ~fclr[c])
                         | {unf[c], ovf[c], match[c] | capt[c]};
      for (int x = 0; x < 2; x++) begin
        if (capt[c][x]) begin
          st_next.gr[c][x] = st_reg.cnt[c];
          if (has_cd && st_reg.ctrl[c][CTL_BUF_LSB + x]) begin
            st_next.gr[c][x + 2] = st_reg.gr[c][x];
          end
        end else if (match[c][x] && has_cd && st_reg.ctrl[c][CTL_BUF_LSB + x]) begin
          st_next.gr[c][x] = st_reg.gr[c][x + 2];
        end
      end
      if (md == MODE_PWM2 && !PWM2_CH_MASK[c]) begin
        md = MODE_NORMAL;
      end
      for (int x = 0; x < 4; x++) begin
        if (x < 2 || has_cd) begin
          case (md)
            MODE_PWM1: begin
              if (x == 0 || x == 2) begin
                st_next.oe[c][x] = 1'b1;
                if (!st_reg.start[c]) begin
                  st_next.pin[c][x] = st_reg.ioc[c][IOC_INIT_LSB + x];
                end else if (st_reg.gr[c][x] != st_reg.gr[c][x + 1]) begin
                  if (match[c][x]) begin
                    st_next.pin[c][x] = apply_act(st_reg.ioc[c][2*x +: 2],
                                                  st_reg.pin[c][x]);
                  end else if (match[c][x + 1]) begin
                    st_next.pin[c][x] = apply_act(st_reg.ioc[c][2*x+2 +: 2],
                                                  st_reg.pin[c][x]);
                  end
                end
              end else begin
                st_next.oe[c][x] = 1'b0;
              end
            end
            MODE_PWM2: begin
              if (per_ok && x == per) begin
                st_next.oe[c][x]  = 1'b0;
                st_next.pin[c][x] = st_reg.ioc[c][IOC_INIT_LSB + x];
              end else begin
                st_next.oe[c][x] = !(x < 2 && st_reg.ioc[c][IOC_CAP_LSB + x]);
                if (!st_reg.start[c] || clr[c]) begin
                  st_next.pin[c][x] = st_reg.ioc[c][IOC_INIT_LSB + x];
                end else if (match[c][x]
                             && !(per_ok && st_reg.gr[c][x] == st_reg.gr[c][per])) begin
                  st_next.pin[c][x] = apply_act(st_reg.ioc[c][2*x +: 2],
                                                st_reg.pin[c][x]);
                end
              end
            end
            default: begin
              st_next.oe[c][x] = !(x < 2 && st_reg.ioc[c][IOC_CAP_LSB + x])
                                 && st_reg.ioc[c][2*x +: 2] != ACT_KEEP;
              if (match[c][x]) begin
                st_next.pin[c][x] = apply_act(st_reg.ioc[c][2*x +: 2],
                                              st_reg.pin[c][x]);
              end
            end
          endcase
        end
      end
    end
    // Software writes win over counting and buffer moves in the same cycle
    if (wr_en) begin
      if (avs_address == OFS_START) begin
        st_next.start = avs_writedata[4:0];
      end else if (chan_ok) begin
        case (regi)
          REG_CTRL:   st_next.ctrl[chn] = avs_writedata[15:0];
          REG_IOC:    st_next.ioc[chn]  = avs_writedata[15:0];
          REG_STATUS: st_next.ctrl[chn] = st_reg.ctrl[chn];
          REG_CNT: begin
            for (int c = 0; c < NCH; c++) begin
              if (c == chn || (st_reg.ctrl[chn][CTL_SYNC] && st_reg.ctrl[c][CTL_SYNC])) begin
                st_next.cnt[c] = avs_writedata[15:0];
              end
            end
          end
          default: begin
            if (!regi[1] || BUF_CH_MASK[chn]) begin
              st_next.gr[chn][regi[1:0]] = avs_writedata[15:0];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg         <= '0;
      st_reg.gr      <= {NCH * 4{GR_RST}};
      st_reg.ctrl    <= {NCH{CTRL_RST}};
      st_reg.ioc     <= {NCH{IOC_RST}};
      st_reg.cnt     <= {NCH{CNT_RST}};
      st_reg.dir     <= '1;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign timer_pin_out   = st_reg.pin;
  assign timer_pin_oe    = st_reg.oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_req_waits;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  a_bus_answer: assert property (s_req_waits |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus request not answered in one wait cycle");
  a_buf_compare: assert property (st_reg.ctrl[0][CTL_BUF_LSB] && match[0][0] && !wr_en
    |=> st_reg.gr[0][0] == $past(st_reg.gr[0][2])) else $error("Compare buffer not loaded");
  a_buf_capture: assert property (st_reg.ctrl[3][CTL_BUF_LSB] && capt[3][0] && !wr_en
    |=> st_reg.gr[3][0] == $past(st_reg.cnt[3]) && st_reg.gr[3][2] == $past(st_reg.gr[3][0]))
    else $error("Capture buffer shift wrong");
  a_cascade_up: assert property (st_reg.start[1] && st_reg.ctrl[1][CTL_CASC]
    && st_reg.ctrl[1][1:0] != MODE_PHASE && ovf[2] && !clr[1] && !wr_en
    |=> st_reg.cnt[1] == $past(st_reg.cnt[1]) + 16'h0001) else $error("Upper half missed carry");
  a_under_phase: assert property (unf[2] |-> st_reg.ctrl[2][1:0] == MODE_PHASE)
    else $error("Underflow outside phase mode");
  a_unf_flag: assert property (unf[2] |=> st_reg.flags[2][ST_UNF])
    else $error("Underflow flag not set");
  a_dir_down: assert property (dn[1] && !up[1] |=> !st_reg.dir[1])
    else $error("Direction flag not down");
  a_pwm1_equal: assert property (st_reg.ctrl[3][1:0] == MODE_PWM1 && st_reg.start[3]
    && st_reg.gr[3][0] == st_reg.gr[3][1] |=> $stable(timer_pin_out[3][0]))
    else $error("Equal pair changed pin");
  a_pwm2_clear: assert property (st_reg.ctrl[0][1:0] == MODE_PWM2 && clr[0]
    |=> timer_pin_out[0][2] == $past(st_reg.ioc[0][IOC_INIT_LSB + 2]))
    else $error("Pin not back at initial level");
  a_period_quiet: assert property (st_reg.ctrl[0][3:0] == {CLR_A, MODE_PWM2} && !wr_en
    |=> !timer_pin_oe[0][0]) else $error("Period pin driven");
endmodule : tbcp_timer
`default_nettype wire

// *** shared/tbcp_pkg.sv ***
`default_nettype none
package tbcp_pkg;
  localparam int NCH = 5;
  // Channel capabilities, one bit per channel
  localparam logic [4:0] BUF_CH_MASK   = 5'h19;
  localparam logic [4:0] PHASE_CH_MASK = 5'h06;
  localparam logic [4:0] PWM2_CH_MASK  = 5'h07;
  localparam int CASC_UPPER = 1;
  localparam int CASC_LOWER = 2;
  // Register map, byte addresses; channel c sits at c * 0x20
  localparam logic [8:0] OFS_START = 9'h100;
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_IOC    = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_CNT    = 3'h3;
  localparam logic [2:0] REG_GRA    = 3'h4;
  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CLR_LSB  = 2;
  localparam int CTL_BUF_LSB  = 4;
  localparam int CTL_CASC     = 6;
  localparam int CTL_SYNC     = 7;
  localparam int CTL_PSC_LSB  = 8;
  // Pin output control fields
  localparam int IOC_ACT_LSB  = 0;
  localparam int IOC_INIT_LSB = 8;
  localparam int IOC_CAP_LSB  = 12;
  // Status fields
  localparam int ST_OVF = 4;
  localparam int ST_UNF = 5;
  localparam int ST_DIR = 6;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] IOC_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] GR_RST   = 16'hffff;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Prescaler taps
  localparam logic [5:0] PRE_DIV4  = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV64 = 6'h3f;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_PWM1 = 2'b01, MODE_PWM2 = 2'b10, MODE_PHASE = 2'b11
  } tbcp_mode_t;
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00, CLR_A = 2'b01, CLR_B = 2'b10, CLR_SYNC = 2'b11
  } tbcp_clr_t;
  typedef enum logic [1:0] {
    ACT_KEEP = 2'b00, ACT_LOW = 2'b01, ACT_HIGH = 2'b10, ACT_TOGGLE = 2'b11
  } tbcp_act_t;
endpackage : tbcp_pkg
`default_nettype wire

// *** shared/tbcp_phase_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface tbcp_phase_if;
  logic up;
  logic dn;
  modport dec (output up, output dn);
  modport cnt (input up, input dn);
endinterface : tbcp_phase_if
`default_nettype wire

// *** rtl/tbcp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbcp_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } tbcp_sync_st_t;
  tbcp_sync_st_t st_reg;
  tbcp_sync_st_t st_next;

  // First stage feeds only the second
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : tbcp_sync
`default_nettype wire

// *** rtl/tbcp_quad_dec.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbcp_quad_dec (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // Encoder phases
  input  wire logic   phase_a,
  input  wire logic   phase_b,
  // Count steps
  tbcp_phase_if.dec   steps
);
  typedef struct packed {
    logic       primed;
    logic [1:0] prev;
    logic       up;
    logic       dn;
  } tbcp_quad_st_t;
  tbcp_quad_st_t st_reg;
  tbcp_quad_st_t st_next;
  logic [1:0]    ab;
  logic          one_change;

  tbcp_sync #(.WIDTH(2)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({phase_a, phase_b}),
    .q       (ab)
  );

  // Every edge of either phase is one step; a double change is noise and is dropped
  always_comb begin
    st_next        = st_reg;
    st_next.primed = 1'b1;
    st_next.prev   = ab;
    one_change     = st_reg.primed && ((st_reg.prev[1] ^ ab[1]) ^ (st_reg.prev[0] ^ ab[0]));
    st_next.up     = one_change && (ab[1] ^ st_reg.prev[0]);
    st_next.dn     = one_change && !(ab[1] ^ st_reg.prev[0]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign steps.up = st_reg.up;
  assign steps.dn = st_reg.dn;

  a_quad_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
    !(st_reg.up && st_reg.dn)) else $error("Quadrature up and down together");
endmodule : tbcp_quad_dec
`default_nettype wire

// *** tb/tbcp_encoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbcp_encoder (
  // Clock
  input  wire logic clk,
  // Encoder phases
  output logic      phase_a,
  output logic      phase_b
);
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
  end
  // One edge per step; each level held eight cycles so the synchroniser sees it
  task automatic move(input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      phase_a <= fwd ? ~phase_b : phase_b;
      phase_b <= fwd ? phase_a : ~phase_a;
      repeat (7) @(posedge clk);
    end
  endtask : move
endmodule : tbcp_encoder
`default_nettype wire

// *** tb/timer_buffer_cascade_pwm_phase_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module timer_buffer_cascade_pwm_phase_tb import tbcp_pkg::*;;
  logic                clk;
  logic                reset_n;
  logic [8:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                enc_a;
  logic                enc_b;
  logic [4:0][3:0]     timer_pin_out;
  logic [4:0][3:0]     timer_pin_oe;
  logic [4:0][3:0]     pin_in;
  int                  failures;
  int                  check_count;
  int                  seed;
  logic [31:0]         q;
  logic [15:0]         v;
  int                  h;

  tbcp_timer DUT (
    .clk             (clk),
    .reset_n         (reset_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .ext_phase_a_ch1 (1'b0),
    .ext_phase_b_ch1 (1'b0),
    .ext_phase_a_ch2 (enc_a),
    .ext_phase_b_ch2 (enc_b),
    .timer_pin_in    (pin_in),
    .timer_pin_out   (timer_pin_out),
    .timer_pin_oe    (timer_pin_oe)
  );

  tbcp_encoder enc (
    .clk     (clk),
    .phase_a (enc_a),
    .phase_b (enc_b)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [8:0] ad(input int c, input int r);
    return {1'b0, c[2:0], r[2:0], 2'b00};
  endfunction : ad

  // High cycles seen in n PWM periods
  function automatic int pwm1_high(input int duty, input int n);
    return n * (duty + 1);
  endfunction : pwm1_high

  function automatic int pwm2_high(input int per, input int duty, input int n);
    return n * (per - duty);
  endfunction : pwm2_high

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {16'h0000, d};
    // Look at waitrequest where it is settled, act on the next rising edge
    @(negedge clk);
    while (avs_waitrequest !== 1'b0) @(negedge clk);
    @(posedge clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic count_high(input int c, input int p, input int n);
    h = 0;
    repeat (30) @(posedge clk);
    repeat (n) begin
      @(negedge clk);
      if (timer_pin_out[c][p] === 1'b1) h++;
    end
  endtask : count_high

  initial begin
    failures = 0;
    check_count = 0;
    seed = 56777;
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    pin_in = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Buffered compare on channel 0; channel 1 has no buffer
    v = 16'($random(seed));
    bus(0, ad(0, 2), 16'h0000);
    chk(q, 32'h0000_0040);
    bus(0, ad(5, 0), 16'h0000);
    chk(q, 32'h0000_0000);
    bus(1, ad(0, 0), 16'h0010);
    bus(1, ad(0, 4), 16'h0003);
    bus(1, ad(0, 6), v);
    bus(1, ad(1, 6), 16'h1234);
    bus(0, ad(1, 6), 16'h0000);
    chk(q, 32'h0000_0000);
    bus(1, OFS_START, 16'h0001);
    repeat (10) @(posedge clk);
    bus(1, OFS_START, 16'h0000);
    bus(0, ad(0, 4), 16'h0000);
    chk(q, {16'h0000, v});
    $display("test buffer done");
    // Phase counting on channel 2 cascaded into channel 1
    bus(1, ad(2, 0), 16'h0003);
    bus(1, ad(1, 0), 16'h0040);
    bus(1, OFS_START, 16'h0006);
    enc.move(1'b0, 4);
    bus(0, ad(2, 3), 16'h0000);
    chk(q, 32'h0000_fffc);
    bus(0, ad(1, 3), 16'h0000);
    chk(q, 32'h0000_ffff);
    bus(0, ad(2, 2), 16'h0000);
    chk(q & 32'h0000_0070, 32'h0000_0020);
    bus(1, ad(2, 2), 16'h0030);
    enc.move(1'b1, 8);
    bus(0, ad(2, 3), 16'h0000);
    chk(q, 32'h0000_0004);
    bus(0, ad(1, 3), 16'h0000);
    chk(q, 32'h0000_0000);
    bus(0, ad(2, 2), 16'h0000);
    chk(q & 32'h0000_0070, 32'h0000_0050);
    bus(1, OFS_START, 16'h0000);
    $display("test phase done");
    // PWM mode 1 on channel 3, random duty
    v = 16'($unsigned($random(seed)) % 9);
    bus(1, ad(3, 0), 16'h0005);
    bus(1, ad(3, 1), 16'h0006);
    bus(1, ad(3, 4), 16'h0009);
    bus(1, ad(3, 5), v);
    chk(32'(timer_pin_out[3][0]), 32'h0000_0000);
    chk(32'({timer_pin_oe[3][1], timer_pin_oe[3][0]}), 32'h0000_0001);
    bus(1, OFS_START, 16'h0008);
    count_high(3, 0, 20);
    chk(32'(h), 32'(pwm1_high(int'(v), 2)));
    bus(1, OFS_START, 16'h0000);
    bus(1, ad(3, 5), 16'h0009);
    bus(1, ad(3, 3), 16'h0000);
    bus(1, OFS_START, 16'h0008);
    count_high(3, 0, 20);
    chk(32'(h), 32'h0000_0000);
    bus(1, OFS_START, 16'h0000);
    $display("test pwm1 done");
    // PWM mode 2 on channel 0, A holds the period
    bus(1, ad(0, 0), 16'h0006);
    bus(1, ad(0, 1), 16'h0008);
    bus(1, ad(0, 4), 16'h0007);
    bus(1, ad(0, 5), 16'h0002);
    bus(1, ad(0, 3), 16'h0000);
    bus(1, OFS_START, 16'h0001);
    count_high(0, 1, 16);
    chk(32'(h), 32'(pwm2_high(7, 2, 2)));
    chk(32'({timer_pin_oe[0][1], timer_pin_oe[0][0]}), 32'h0000_0002);
    bus(1, OFS_START, 16'h0000);
    $display("test pwm2 done");
    // Buffered capture on channel 3, counter held still
    bus(1, ad(3, 0), 16'h0010);
    bus(1, ad(3, 1), 16'h1000);
    bus(1, ad(3, 4), 16'h0005);
    bus(1, ad(3, 3), 16'h0100);
    @(posedge clk);
    pin_in[3][0] <= 1'b1;
    repeat (8) @(posedge clk);
    bus(0, ad(3, 4), 16'h0000);
    chk(q, 32'h0000_0100);
    bus(0, ad(3, 6), 16'h0000);
    chk(q, 32'h0000_0005);
    $display("test capture done");
    test_done;
  end

  // Whole run needs about 400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule : timer_buffer_cascade_pwm_phase_tb
`default_nettype wire
